// File: hw/qgbl_tap.sv
`timescale 1ns/1ps
module qgbl_tap (
    input  wire logic                     pclk,      // clock
    input  wire logic                     presetn,   // async reset, active low
    qgbl_tap_if.chan                      cfg,       // channel settings
    input  wire logic                     in_valid,  // sample strobe
    input  wire logic [qgbl_pkg::PIX_W-1:0] in_data, // raw 12 bit sample
    output logic                          out_valid, // result strobe
    output logic [qgbl_pkg::PIX_W-1:0]    out_data   // adjusted pixel
);
    import qgbl_pkg::*;
    localparam int SUM_W = PIX_W + MULT_W - MANT_Q + 1;

    logic [VAL_W+LOG2_W-1:0]  lg;
    logic [1:0]               e_int;
    logic [MANT_Q-1:0]        e_frac;
    logic [MULT_W-1:0]        mult;
    logic [PIX_W+MULT_W-1:0]  prod;
    logic [VAL_W-1:0]         off;
    logic [SUM_W-1:0]         sum;
    logic [SUM_W-1:0]         s1_sum;
    logic                     s1_valid;
    logic                     s1_d12;
    logic [PIX_W-1:0]         sat;
    logic [PIX_W:0]           ref12;

    ////////////////////////////////////////////////////////////////////////
    // gain steps to a linear q8 multiplier, piecewise-linear power of two
    assign lg     = cfg.gain_total * GAIN_LOG2_SCALE;
    assign e_int  = lg[LOG2_Q +: 2];
    assign e_frac = lg[LOG2_Q-MANT_Q +: MANT_Q];
    assign mult   = {{(MULT_W-MANT_Q-1){1'b0}}, 1'b1, e_frac} << e_int;
    assign prod   = in_data * mult;
    // black level offset in twelve-bit codes
    assign off    = cfg.bl_total >> BL_SHIFT12;
    assign sum    = SUM_W'(prod[PIX_W+MULT_W-1:MANT_Q]) + SUM_W'(off);

    // first stage: gain and offset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_valid <= 1'b0;
            s1_sum   <= '0;
            s1_d12   <= 1'b0;
        end else begin
            s1_valid <= in_valid;
            s1_sum   <= sum;
            s1_d12   <= cfg.depth12;
        end
    end

    // second stage: saturate, then drop four bits for eight-bit depth
    assign sat = (s1_sum > SUM_W'(PIX_MAX)) ? PIX_MAX : s1_sum[PIX_W-1:0];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            out_valid <= s1_valid;
            out_data  <= s1_d12 ? sat : (sat >> DEPTH_SHIFT8);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks: unity-gain reference result
    assign ref12 = ((PIX_W+1)'(in_data) + (PIX_W+1)'(off) > (PIX_W+1)'(PIX_MAX)) ?
                   (PIX_W+1)'(PIX_MAX) : (PIX_W+1)'(in_data) + (PIX_W+1)'(off);

    a_tap_latency: assert property (@(posedge pclk) disable iff (!presetn)
        in_valid |-> ##2 out_valid)
        else $error("tap result not two cycles after sample");
    a_pix_saturate: assert property (@(posedge pclk) disable iff (!presetn)
        out_valid |-> out_data <= ($past(s1_d12) ? PIX_MAX : PIX8_MAX))
        else $error("pixel above depth maximum");
    a_bl_step12: assert property (@(posedge pclk) disable iff (!presetn)
        (in_valid && cfg.gain_total == '0 && cfg.depth12)
        |-> ##2 out_data == $past(ref12[PIX_W-1:0], 2))
        else $error("twelve-bit black level offset wrong");
    a_bl_step8: assert property (@(posedge pclk) disable iff (!presetn)
        (in_valid && cfg.gain_total == '0 && !cfg.depth12)
        |-> ##2 out_data == ($past(ref12[PIX_W-1:0], 2) >> DEPTH_SHIFT8))
        else $error("eight-bit black level offset wrong");
endmodule : qgbl_tap

// File: hw/qgbl_top.sv
`timescale 1ns/1ps
module qgbl_top (
    input  wire logic                                   pclk,         // 40 MHz clock
    input  wire logic                                   presetn,      // async reset, low
    input  wire logic [qgbl_pkg::ADDR_W-1:0]            paddr,        // apb address
    input  wire logic                                   psel,         // apb select
    input  wire logic                                   penable,      // apb access phase
    input  wire logic                                   pwrite,       // apb direction
    input  wire logic [qgbl_pkg::DATA_W-1:0]            pwdata,       // apb write data
    output logic [qgbl_pkg::DATA_W-1:0]                 prdata,       // apb read data
    output logic                                        pready,       // apb ready
    output logic                                        pslverr,      // apb error
    input  wire logic [qgbl_pkg::NUM_TAPS-1:0]          tap_valid,    // sample strobes
    input  wire logic [qgbl_pkg::NUM_TAPS-1:0][qgbl_pkg::PIX_W-1:0] tap_data, // samples
    output logic [qgbl_pkg::NUM_TAPS-1:0]               out_valid,    // result strobes
    output logic [qgbl_pkg::NUM_TAPS-1:0][qgbl_pkg::PIX_W-1:0] out_data,  // results
    output logic                                        gain_auto_en  // auto gain enable
);
    import qgbl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // settings and decode

    logic                              four_tap;
    logic                              depth12;
    logic                              gain_auto;
    qgbl_sel_t                         gsel;
    qgbl_sel_t                         bsel;
    logic [VAL_W-1:0]                  gain_all;
    logic [VAL_W-1:0]                  bl_all;
    logic [NUM_TAPS-1:0][VAL_W-1:0]    gain_tap;
    logic [NUM_TAPS-1:0][VAL_W-1:0]    bl_tap;
    logic                              clamped;
    logic                              refused;
    logic [VAL_W-1:0]                  max_gt;
    logic [VAL_W-1:0]                  max_bt;
    logic [VAL_W-1:0]                  gain_lim;
    logic [VAL_W-1:0]                  bl_lim;
    logic [VAL_W-1:0]                  gain_val;
    logic [VAL_W-1:0]                  bl_val;
    logic [1:0]                        gidx;
    logic [1:0]                        bidx;
    logic [DATA_W-1:0]                 next_prdata;
    logic                              addr_ok;
    logic                              setup;
    logic                              wr;
    logic                              wr_ctrl;
    logic                              wr_gsel;
    logic                              wr_graw;
    logic                              wr_bsel;
    logic                              wr_braw;
    logic [NUM_TAPS-1:0]               lane_en;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // clamp a written word to zero .. hi; negative words count as below range
    function automatic logic [VAL_W-1:0] clamp_val(input logic [DATA_W-1:0] v,
                                                   input logic [VAL_W-1:0]  hi);
        if (v[DATA_W-1])
            return '0;
        else if (v > {{(DATA_W-VAL_W){1'b0}}, hi})
            return hi;
        else
            return v[VAL_W-1:0];
    endfunction : clamp_val

    // largest of the four per-tap settings
    function automatic logic [VAL_W-1:0] max4(
        input logic [NUM_TAPS-1:0][VAL_W-1:0] v);
        logic [VAL_W-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_TAPS; i++) begin
            if (v[i] > m)
                m = v[i];
        end
        return m;
    endfunction : max4

    // selector word from a write, out-of-range codes land on the last tap
    function automatic qgbl_sel_t sel_val(input logic [DATA_W-1:0] v,
                                          input logic              four);
        if (!four)
            return SEL_ALL;
        else if (v > DATA_W'(SEL_TAP4))
            return SEL_TAP4;
        else
            return qgbl_sel_t'(v[SEL_W-1:0]);
    endfunction : sel_val

    // value seen through a selector
    function automatic logic [DATA_W-1:0] sel_read(
        input qgbl_sel_t                      s,
        input logic [VAL_W-1:0]               all,
        input logic [NUM_TAPS-1:0][VAL_W-1:0] tap);
        if (s == SEL_ALL)
            return DATA_W'(all);
        else
            return DATA_W'(tap[2'(s - SEL_TAP1)]);
    endfunction : sel_read

    ////////////////////////////////////////////////////////////////////////
    // apb strobes; zero wait states

    assign setup   = psel && !penable;
    assign wr      = psel && penable && pwrite;
    assign wr_ctrl = wr && (paddr == OFF_CTRL);
    assign wr_gsel = wr && (paddr == OFF_GSEL);
    assign wr_graw = wr && (paddr == OFF_GRAW);
    assign wr_bsel = wr && (paddr == OFF_BSEL);
    assign wr_braw = wr && (paddr == OFF_BRAW);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign gain_auto_en = gain_auto;

    // limits for the next raw write follow from the other term of each sum
    assign max_gt   = max4(gain_tap);
    assign max_bt   = max4(bl_tap);
    assign gidx     = 2'(gsel - SEL_TAP1);
    assign bidx     = 2'(bsel - SEL_TAP1);
    assign gain_lim = (gsel == SEL_ALL) ? GAIN_MAX - max_gt : GAIN_MAX - gain_all;
    assign bl_lim   = (bsel == SEL_ALL) ? BL_MAX - max_bt : BL_MAX - bl_all;
    assign gain_val = clamp_val(pwdata, gain_lim);
    assign bl_val   = clamp_val(pwdata, bl_lim);

    ////////////////////////////////////////////////////////////////////////
    // control word; automatic functions come up off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            four_tap  <= CTRL_RST[CTRL_FOUR_TAP];
            depth12   <= CTRL_RST[CTRL_DEPTH12];
            gain_auto <= CTRL_RST[CTRL_GAIN_AUTO];
        end else if (wr_ctrl) begin
            four_tap  <= pwdata[CTRL_FOUR_TAP];
            depth12   <= pwdata[CTRL_DEPTH12];
            gain_auto <= pwdata[CTRL_GAIN_AUTO];
        end
    end

    // selectors; one-tap mode only reaches the global setting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gsel <= SEL_ALL;
            bsel <= SEL_ALL;
        end else if (wr_ctrl && !pwdata[CTRL_FOUR_TAP]) begin
            gsel <= SEL_ALL;
            bsel <= SEL_ALL;
        end else begin
            if (wr_gsel)
                gsel <= sel_val(pwdata, four_tap);
            if (wr_bsel)
                bsel <= sel_val(pwdata, four_tap);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // gain settings; raw writes land in the selected setting while automatic gain is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_all <= '0;
            gain_tap <= '0;
        end else if (wr_graw && !gain_auto) begin
            if (gsel == SEL_ALL)
                gain_all <= gain_val;
            else if (four_tap)
                gain_tap[gidx] <= gain_val;
        end
    end

    // black level settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bl_all <= '0;
            bl_tap <= '0;
        end else if (wr_braw) begin
            if (bsel == SEL_ALL)
                bl_all <= bl_val;
            else if (four_tap)
                bl_tap[bidx] <= bl_val;
        end
    end

    // status of the last raw write: limited, or refused under auto gain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clamped <= 1'b0;
            refused <= 1'b0;
        end else if (wr_graw) begin
            clamped <= (pwdata != DATA_W'(gain_val));
            refused <= gain_auto;
        end else if (wr_braw) begin
            clamped <= (pwdata != DATA_W'(bl_val));
            refused <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read decode
    always_comb begin
        next_prdata = '0;
        addr_ok     = 1'b1;
        if (paddr == OFF_CTRL) begin
            next_prdata[CTRL_FOUR_TAP]  = four_tap;
            next_prdata[CTRL_DEPTH12]   = depth12;
            next_prdata[CTRL_GAIN_AUTO] = gain_auto;
        end else if (paddr == OFF_GSEL) begin
            next_prdata = DATA_W'(gsel);
        end else if (paddr == OFF_GRAW) begin
            next_prdata = sel_read(gsel, gain_all, gain_tap);
        end else if (paddr == OFF_BSEL) begin
            next_prdata = DATA_W'(bsel);
        end else if (paddr == OFF_BRAW) begin
            next_prdata = sel_read(bsel, bl_all, bl_tap);
        end else if (paddr == OFF_STAT) begin
            next_prdata[STAT_CLAMPED] = clamped;
            next_prdata[STAT_REFUSED] = refused;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // read data is captured in the setup cycle and held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= '0;
        else if (setup && !pwrite)
            prdata <= next_prdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // tap channels; one-tap mode runs lane zero with the global terms only

    assign lane_en = four_tap ? {NUM_TAPS{1'b1}} : NUM_TAPS'(1);

    qgbl_tap_if tif [NUM_TAPS] ();

    for (genvar i = 0; i < NUM_TAPS; i++) begin : g_tap
        // per-quadrant totals: common global term plus the tap term
        assign tif[i].gain_total = four_tap ? VAL_W'(gain_all + gain_tap[i])
                                            : gain_all;
        assign tif[i].bl_total   = four_tap ? VAL_W'(bl_all + bl_tap[i])
                                            : bl_all;
        assign tif[i].depth12    = depth12;

        qgbl_tap u_tap (
            .pclk      (pclk),
            .presetn   (presetn),
            .cfg       (tif[i]),
            .in_valid  (tap_valid[i] && lane_en[i]),
            .in_data   (tap_data[i]),
            .out_valid (out_valid[i]),
            .out_data  (out_data[i])
        );

        a_tap_gain_sum: assert property (@(posedge pclk) disable iff (!presetn)
            four_tap |-> (VAL_W+1)'(tif[i].gain_total) ==
                         (VAL_W+1)'(gain_all) + (VAL_W+1)'(gain_tap[i]))
            else $error("quadrant gain is not global plus tap");
        a_tap_bl_sum: assert property (@(posedge pclk) disable iff (!presetn)
            four_tap |-> (VAL_W+1)'(tif[i].bl_total) ==
                         (VAL_W+1)'(bl_all) + (VAL_W+1)'(bl_tap[i]))
            else $error("quadrant black level is not global plus tap");
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_graw_wr;
        psel && penable && pwrite && paddr == OFF_GRAW;
    endsequence
    sequence s_braw_wr;
        psel && penable && pwrite && paddr == OFF_BRAW;
    endsequence
    sequence s_gsel_wr;
        psel && penable && pwrite && paddr == OFF_GSEL;
    endsequence

    a_auto_off_reset: assert property (
        !$past(presetn) |-> !gain_auto && !gain_auto_en)
        else $error("automatic gain on after reset");

    a_gain_auto_lock: assert property (
        gain_auto ##0 s_graw_wr |=> $stable(gain_all) && $stable(gain_tap) && refused)
        else $error("gain changed while automatic gain on");

    a_refused_clear: assert property (
        s_graw_wr ##0 !gain_auto |=> !refused)
        else $error("manual gain write flagged as refused");

    a_gain_range: assert property (
        gain_all <= GAIN_MAX && max_gt <= GAIN_MAX)
        else $error("gain setting out of range");

    // sums widened by one bit so a wrapped total cannot slip through
    a_gain_sum_limit: assert property (
        (VAL_W+1)'(gain_all) + (VAL_W+1)'(max_gt) <= (VAL_W+1)'(GAIN_MAX))
        else $error("gain sum above limit");

    a_bl_range: assert property (
        bl_all <= BL_MAX && max_bt <= BL_MAX)
        else $error("black level setting out of range");

    a_bl_sum_limit: assert property (
        (VAL_W+1)'(bl_all) + (VAL_W+1)'(max_bt) <= (VAL_W+1)'(BL_MAX))
        else $error("black level sum above limit");

    a_clamp_high: assert property (
        s_graw_wr ##0 (!gain_auto && gsel == SEL_ALL && !pwdata[DATA_W-1] &&
                       pwdata > DATA_W'(GAIN_MAX))
        |=> gain_all == GAIN_MAX - $past(max_gt) && clamped)
        else $error("high gain write not held at limit");

    a_tap_clamp: assert property (
        s_graw_wr ##0 (!gain_auto && four_tap && gsel != SEL_ALL && !pwdata[DATA_W-1] &&
                       pwdata > DATA_W'(gain_lim))
        |=> gain_tap[$past(gidx)] == GAIN_MAX - gain_all)
        else $error("tap gain write not held at sum limit");

    a_bl_clamp_high: assert property (
        s_braw_wr ##0 (bsel == SEL_ALL && !pwdata[DATA_W-1] && pwdata > DATA_W'(BL_MAX))
        |=> bl_all == BL_MAX - $past(max_bt) && clamped)
        else $error("high black level write not held at limit");

    a_bl_tap_clamp: assert property (
        s_braw_wr ##0 (four_tap && bsel != SEL_ALL && !pwdata[DATA_W-1] &&
                       pwdata > DATA_W'(bl_lim))
        |=> bl_tap[$past(bidx)] == BL_MAX - bl_all)
        else $error("tap black level write not held at sum limit");

    a_clamp_low: assert property (
        s_braw_wr ##0 (bsel == SEL_ALL && pwdata[DATA_W-1]) |=> bl_all == '0)
        else $error("negative black level not held at zero");

    a_one_tap_sel: assert property (
        s_gsel_wr ##0 !four_tap |=> gsel == SEL_ALL ##1 gsel == SEL_ALL)
        else $error("tap selector reachable in one-tap mode");

    a_one_tap_lane: assert property (
        !four_tap && tap_valid[1] |-> ##2 !out_valid[1])
        else $error("second lane produced a pixel in one-tap mode");

    a_gain_lands: assert property (
        s_graw_wr ##0 (!gain_auto && gsel == SEL_ALL && pwdata <= DATA_W'(gain_lim))
        |=> gain_all == $past(pwdata[VAL_W-1:0]))
        else $error("in-range gain write lost");

    a_bl_lands: assert property (
        s_braw_wr ##0 (bsel == SEL_ALL && pwdata <= DATA_W'(bl_lim))
        |=> bl_all == $past(pwdata[VAL_W-1:0]))
        else $error("in-range black level write lost");
endmodule : qgbl_top

// File: include/qgbl_pkg.sv
// Behaviour
// - manual gain writes take effect only while automatic gain is off
// - reset leaves automatic gain and other automatic functions disabled
// - four-tap mode runs four quadrant channels with independent totals
// - global gain is the common term of every quadrant's total gain
// - tap one to four gain adds to global for its quadrant
// - global and per-tap gain settings accept only zero to six hundred
// - global plus any tap gain stays within zero to six hundred
// - tap gain in dB is 0.0359 times global plus tap setting
// - one-tap mode exposes only the global gain, same limits and method
// - black level adds an offset: global term plus per-tap term
// - tap one to four black level adds to global for its quadrant
// - at eight-bit depth sixty-four black level counts move output by one
// - at twelve-bit depth four black level counts move output by one
// - global plus any tap black level stays at or below 950
// - global black level is the common term of every quadrant's total
// - out-of-range writes store the nearest limit instead
package qgbl_pkg;
    localparam int NUM_TAPS = 4;
    localparam int VAL_W    = 10;
    localparam int PIX_W    = 12;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int SEL_W    = 3;
    localparam int MULT_W   = 12;   // gain multiplier, q8
    localparam int MANT_Q   = 8;    // fraction bits of the multiplier
    localparam int LOG2_Q   = 16;   // fraction bits of the log2 product
    localparam int LOG2_W   = 9;

    // setting limits
    localparam logic [VAL_W-1:0] GAIN_MAX = 10'h258;
    localparam logic [VAL_W-1:0] BL_MAX   = 10'h3b6;
    localparam logic [PIX_W-1:0] PIX_MAX  = 12'hfff;
    localparam logic [PIX_W-1:0] PIX8_MAX = 12'h0ff;

    // black level scaling: 4 counts per 12 bit code, then 16 codes per 8 bit code
    localparam int BL_SHIFT12   = 2;
    localparam int DEPTH_SHIFT8 = 4;
    // 0.0359 dB per step over 6.0206 dB per octave, in q16 log2 units
    localparam logic [LOG2_W-1:0] GAIN_LOG2_SCALE = 9'h187;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_GSEL = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_GRAW = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_BSEL = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_BRAW = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h14;

    // control and status fields
    localparam int CTRL_FOUR_TAP  = 0;
    localparam int CTRL_DEPTH12   = 1;
    localparam int CTRL_GAIN_AUTO = 2;
    localparam int STAT_CLAMPED   = 0;
    localparam int STAT_REFUSED   = 1;
    localparam logic [2:0] CTRL_RST = 3'h1;

    typedef enum logic [SEL_W-1:0] {
        SEL_ALL  = 3'h0,
        SEL_TAP1 = 3'h1,
        SEL_TAP2 = 3'h2,
        SEL_TAP3 = 3'h3,
        SEL_TAP4 = 3'h4
    } qgbl_sel_t;
endpackage : qgbl_pkg

// File: include/qgbl_tap_if.sv
`timescale 1ns/1ps
// per-channel settings handed from the register file to a tap channel
interface qgbl_tap_if;
    import qgbl_pkg::*;
    logic [VAL_W-1:0] gain_total;  // global plus tap gain steps
    logic [VAL_W-1:0] bl_total;    // global plus tap black level
    logic             depth12;     // 1: twelve-bit output, 0: eight-bit
    modport ctrl (output gain_total, output bl_total, output depth12);
    modport chan (input gain_total, input bl_total, input depth12);
endinterface : qgbl_tap_if

// File: verification/qgbl_tap_model.sv
`timescale 1ns/1ps
// far-side digitizers: one sample per lane per cycle while go is held
module qgbl_tap_model (
    input  wire logic                                  pclk,      // clock
    input  wire logic                                  presetn,   // async reset, low
    input  wire logic                                  go,        // emit this cycle
    input  wire logic [3:0][qgbl_pkg::PIX_W-1:0]       smp,       // samples to emit
    output logic      [3:0]                            tap_valid, // sample strobes
    output logic      [3:0][qgbl_pkg::PIX_W-1:0]       tap_data   // sample data
);
    import qgbl_pkg::*;
    // idle data toggles so a stale sample never passes for a fresh one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tap_valid <= 4'h0;
            tap_data  <= '0;
        end else if (go) begin
            tap_valid <= 4'hf;
            tap_data  <= smp;
        end else begin
            tap_valid <= 4'h0;
            tap_data  <= ~tap_data;
        end
    end
endmodule : qgbl_tap_model

// File: verification/quadrant_gain_black_level_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: %h vs %h", $time, a, e); end end
module quadrant_gain_black_level_bench;
    import qgbl_pkg::*;
    logic             pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
    logic [7:0]       paddr = 0;
    logic [31:0]      pwdata = 0, prdata, rd;
    logic             pready, pslverr, gain_auto_en, err;
    logic [3:0]       tap_valid, out_valid;
    logic [3:0][11:0] tap_data, out_data, smp = '0;
    logic [11:0]      exq[4][$], exp_px;
    int               fail_count = 0, checked = 0, g_all, g_tap[4], b_all, b_tap[4];
    qgbl_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tap_valid(tap_valid), .tap_data(tap_data),
        .out_valid(out_valid), .out_data(out_data), .gain_auto_en(gain_auto_en));
    qgbl_tap_model far (.pclk(pclk), .presetn(presetn), .go(go), .smp(smp),
        .tap_valid(tap_valid), .tap_data(tap_data));
    initial forever #12.5 pclk = ~pclk;
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) fail_count++;
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic wr(input logic [7:0] a, input int d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 0);
        `CHK(rd, e)
    endtask : rdchk
    // expected pixel: q8 gain multiplier, black level offset, saturation
    function automatic logic [11:0] px(logic [11:0] d, int g, int b, logic d12);
        int lg, m, s;
        lg = g * 391;
        m = (256 + ((lg >> 8) & 255)) << ((lg >> 16) & 3);
        s = ((d * m) >> 8) + (b >> 2);
        if (s > 4095) s = 4095;
        return d12 ? 12'(s) : 12'(s >> 4);
    endfunction : px
    // four back-to-back random samples, expectations noted per lane
    task automatic send(input logic d12, input logic one);
        logic [3:0][11:0] v;
        for (int k = 0; k < 4; k++) begin
            @(posedge pclk);
            for (int i = 0; i < 4; i++) v[i] = 12'($urandom);
            go <= 1'b1;
            smp <= v;
            for (int i = 0; i < (one ? 1 : 4); i++)
                exq[i].push_back(px(v[i], g_all + (one ? 0 : g_tap[i]),
                                 b_all + (one ? 0 : b_tap[i]), d12));
        end
        @(posedge pclk);
        go <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : send
    // each result strobe takes the oldest note of its lane
    always @(posedge pclk) for (int i = 0; i < 4; i++) if (out_valid[i] === 1'b1) begin
        if (exq[i].size() == 0) `CHK(out_valid[i], 1'b0)
        else begin
            exp_px = exq[i].pop_front();
            `CHK(out_data[i], exp_px)
        end
    end
    task automatic finish_test();
        if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    initial begin
        #100us;
        fail_count++;
        finish_test();
    end
    initial begin
        void'($urandom(73));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(OFF_CTRL, 1);
        `CHK(gain_auto_en, 1'b0)
        wr(OFF_GSEL, SEL_ALL);
        wr(OFF_GRAW, 700);
        rdchk(OFF_GRAW, 600);
        rdchk(OFF_STAT, 1);
        wr(OFF_GSEL, SEL_TAP1);
        wr(OFF_GRAW, 5);
        rdchk(OFF_GRAW, 0);
        wr(OFF_GSEL, SEL_ALL);
        wr(OFF_GRAW, 0);
        wr(OFF_GSEL, SEL_TAP2);
        wr(OFF_GRAW, 256);
        g_tap[1] = 256;
        wr(OFF_BSEL, SEL_ALL);
        wr(OFF_BRAW, 1000);
        rdchk(OFF_BRAW, 950);
        wr(OFF_BRAW, -5);
        rdchk(OFF_BRAW, 0);
        wr(OFF_BRAW, 40);
        b_all = 40;
        wr(OFF_BSEL, SEL_TAP3);
        wr(OFF_BRAW, 2000);
        rdchk(OFF_BRAW, 910);
        wr(OFF_BRAW, 400);
        b_tap[2] = 400;
        wr(OFF_CTRL, 3);
        send(1'b1, 1'b0);
        wr(OFF_CTRL, 1);
        send(1'b0, 1'b0);
        wr(OFF_CTRL, 7);
        wr(OFF_GSEL, SEL_ALL);
        wr(OFF_GRAW, 100);
        rdchk(OFF_GRAW, 0);
        rdchk(OFF_STAT, 2);
        `CHK(gain_auto_en, 1'b1)
        wr(OFF_CTRL, 2);
        rdchk(OFF_GSEL, 0);
        wr(OFF_GSEL, SEL_TAP2);
        rdchk(OFF_GSEL, 0);
        send(1'b1, 1'b1);
        wr(OFF_CTRL, 7);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(OFF_CTRL, 1);
        `CHK(gain_auto_en, 1'b0)
        apb(1'b1, 8'h40, 5);
        `CHK(err, 1'b1)
        finish_test();
    end
endmodule : quadrant_gain_black_level_bench
